// File: pkg/abm_cfg.svh
`ifndef ABM_CFG_SVH
`define ABM_CFG_SVH

// Register offsets.
`define ABM_ADDR_FLAGS 8'h04
`define ABM_ADDR_ALT_SEL 8'h0b
`define ABM_ADDR_LIMITS_A 8'h16
`define ABM_ADDR_LIMITS_B 8'h1c
`define ABM_ADDR_OFFSET_A 8'h18
`define ABM_ADDR_OFFSET_B 8'h1e

// Field positions.
`define ABM_THRESH_MSB 13
`define ABM_LIMIT_LSB 14
`define ABM_ALT0_LSB 0
`define ABM_ALT1_LSB 8
`define ABM_ALT_MASK 16'h1f1f

// Reset values.
`define ABM_RESET_WORD 16'h0000
`define ABM_RESET_FLAGS 8'h00

// Pin routing codes.
`define ABM_ALT_OR_A 5'h10
`define ABM_ALT_OR_B 5'h1a
`define ABM_ALT_OR_ALL 5'h1b
`define ABM_ALT_OR_ALL_INT 5'h1c

// Exceedance counts that set a flag, per limit code.
`define ABM_LIMIT_NEVER 2'h0
`define ABM_COUNT_L1 5'h01
`define ABM_COUNT_L2 5'h04
`define ABM_COUNT_L3 5'h10

// Pulse positions of the LED-masked pulses in a four-pulse group.
`define ABM_PULSE_FIRST 2'h0
`define ABM_PULSE_FOURTH 2'h3

`endif

// File: pkg/abm_pkg.sv
package abm_pkg;

  // One conversion result as delivered by the pulse sequencer.
  typedef struct packed {
    logic slot_b;
    logic [1:0] channel;
    logic [1:0] pulse;
    logic [15:0] raw;
  } abm_sample_type;

  // Per-slot configuration word.
  typedef struct packed {
    logic [1:0] limit;
    logic [13:0] thresh;
  } abm_slot_cfg_type;

endpackage

// File: src/abm_monitor.sv
`timescale 1ns/1ns
`include "abm_cfg.svh"
// Overview of operation
// - Compare float-mode subtract-cycle results to slot threshold
// - Only LED-masked pulses are compared
// - Compare raw result minus slot/channel offset
// - Count when corrected result strictly exceeds threshold
// - One independent counter per slot channel
// - Set channel flag when count reaches limit
// - Limit codes: never, one, four, sixteen
// - Flags 3:0 slot A, 7:4 slot B
// - Reading flags returns them then clears
// - First pin routes OR of flags by code
// - Second pin uses same codes, bits 12:8
// - First and fourth pulses are subtract cycles
module abm_monitor #(
  parameter int ADC_W = 14
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Conversion results from the sequencer.
  input wire logic float_mode_in,
  input wire logic sample_valid_in,
  input wire abm_pkg::abm_sample_type sample_in,
  input wire logic int_in,
  // Register access.
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // Routed pins.
  output logic aux_pin_zero_out,
  output logic aux_pin_one_out
);

  if (ADC_W < 1 || ADC_W > 16) begin
    $error("ADC_W must lie between 1 and 16.");
  end

  abm_pkg::abm_slot_cfg_type slot_a_background_limits_q;
  abm_pkg::abm_slot_cfg_type slot_a_background_limits_d;
  abm_pkg::abm_slot_cfg_type slot_b_background_limits_q;
  abm_pkg::abm_slot_cfg_type slot_b_background_limits_d;
  logic [15:0] aux_pin_alternate_select_q;
  logic [15:0] aux_pin_alternate_select_d;
  logic [15:0] offset_q [8];
  logic [15:0] offset_d [8];
  logic [4:0] count_q [8];
  logic [4:0] count_d [8];
  logic [7:0] background_flags_q;
  logic [7:0] background_flags_d;
  logic [15:0] rdata_d;
  logic pin0_d;
  logic pin1_d;

  logic [2:0] sel_idx;
  logic [4:0] sel_cnt;
  logic [4:0] sel_need;
  logic [1:0] sel_limit;
  logic subtract;
  logic exceed;
  logic rd_flags;
  logic [16:0] diff;
  abm_pkg::abm_slot_cfg_type sel_cfg;
  logic [ADC_W-1:0] raw_used;
  logic [3:0] off_sel;

  // Offset register number for an address, with a hit flag in bit 3.
  function automatic logic [3:0] offset_slot(input logic [7:0] addr);
    logic [7:0] rel_a;
    logic [7:0] rel_b;
    rel_a = addr - `ABM_ADDR_OFFSET_A;
    rel_b = addr - `ABM_ADDR_OFFSET_B;
    if (rel_a < 8'h04) begin
      offset_slot = {2'b10, rel_a[1:0]};
    end else if (rel_b < 8'h04) begin
      offset_slot = {2'b11, rel_b[1:0]};
    end else begin
      offset_slot = 4'h0;
    end
  endfunction

  // Exceedances needed before a flag sets; zero means never.
  function automatic logic [4:0] limit_count(input logic [1:0] code);
    unique case (code)
      2'h1: limit_count = `ABM_COUNT_L1;
      2'h2: limit_count = `ABM_COUNT_L2;
      2'h3: limit_count = `ABM_COUNT_L3;
      default: limit_count = 5'h00;
    endcase
  endfunction

  // Level driven onto a routed pin for a selection code.
  function automatic logic pin_level(input logic [4:0] code,
                                     input logic [7:0] flags,
                                     input logic irq);
    unique case (code)
      `ABM_ALT_OR_A: pin_level = |flags[3:0];
      `ABM_ALT_OR_B: pin_level = |flags[7:4];
      `ABM_ALT_OR_ALL: pin_level = |flags;
      `ABM_ALT_OR_ALL_INT: pin_level = (|flags) | irq;
      default: pin_level = 1'b0;
    endcase
  endfunction

  always_comb begin
    sel_idx = {sample_in.slot_b, sample_in.channel};
    sel_cnt = count_q[sel_idx];
    sel_cfg = sample_in.slot_b ? slot_b_background_limits_q
                               : slot_a_background_limits_q;
    sel_limit = sel_cfg.limit;
    sel_need = limit_count(sel_limit);
    subtract = float_mode_in &&
               (sample_in.pulse == `ABM_PULSE_FIRST ||
                sample_in.pulse == `ABM_PULSE_FOURTH);
    raw_used = sample_in.raw[ADC_W-1:0];
    // Negative corrected results never count as ambient excess.
    diff = {1'b0, 16'(raw_used)} - {1'b0, offset_q[sel_idx]};
    exceed = sample_valid_in && subtract && !diff[16] &&
             diff[15:0] > {2'b00, sel_cfg.thresh};
    rd_flags = reg_rd_in && reg_addr_in == `ABM_ADDR_FLAGS;
    off_sel = offset_slot(reg_addr_in);
  end

  always_comb begin
    slot_a_background_limits_d = slot_a_background_limits_q;
    slot_b_background_limits_d = slot_b_background_limits_q;
    aux_pin_alternate_select_d = aux_pin_alternate_select_q;
    offset_d = offset_q;
    if (reg_wr_in) begin
      if (reg_addr_in == `ABM_ADDR_LIMITS_A) begin
        slot_a_background_limits_d = reg_wdata_in;
      end
      if (reg_addr_in == `ABM_ADDR_LIMITS_B) begin
        slot_b_background_limits_d = reg_wdata_in;
      end
      if (reg_addr_in == `ABM_ADDR_ALT_SEL) begin
        aux_pin_alternate_select_d = reg_wdata_in & `ABM_ALT_MASK;
      end
      if (off_sel[3]) begin
        offset_d[off_sel[2:0]] = reg_wdata_in;
      end
    end
  end

  always_comb begin
    logic [4:0] base;
    logic [4:0] next;
    base = 5'h00;
    next = 5'h00;
    count_d = count_q;
    // Set wins: a flag raised in the read cycle survives the clear.
    background_flags_d = rd_flags ? `ABM_RESET_FLAGS
                                  : background_flags_q;
    for (int i = 0; i < 8; i++) begin
      if (rd_flags && background_flags_q[i]) begin
        count_d[i] = 5'h00;
      end
    end
    if (exceed) begin
      base = (rd_flags && background_flags_q[sel_idx]) ? 5'h00 : sel_cnt;
      // Saturate so the count cannot wrap past the largest limit.
      next = (base == `ABM_COUNT_L3) ? base : base + 5'h01;
      count_d[sel_idx] = next;
      if (sel_limit != `ABM_LIMIT_NEVER && next >= sel_need) begin
        background_flags_d[sel_idx] = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_d = `ABM_RESET_WORD;
    if (reg_rd_in) begin
      if (reg_addr_in == `ABM_ADDR_FLAGS) begin
        rdata_d = {8'h00, background_flags_q};
      end else if (reg_addr_in == `ABM_ADDR_ALT_SEL) begin
        rdata_d = aux_pin_alternate_select_q;
      end else if (reg_addr_in == `ABM_ADDR_LIMITS_A) begin
        rdata_d = slot_a_background_limits_q;
      end else if (reg_addr_in == `ABM_ADDR_LIMITS_B) begin
        rdata_d = slot_b_background_limits_q;
      end else if (off_sel[3]) begin
        rdata_d = offset_q[off_sel[2:0]];
      end
    end
    pin0_d = pin_level(aux_pin_alternate_select_q[`ABM_ALT0_LSB +: 5],
                       background_flags_q, int_in);
    pin1_d = pin_level(aux_pin_alternate_select_q[`ABM_ALT1_LSB +: 5],
                       background_flags_q, int_in);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      slot_a_background_limits_q <= `ABM_RESET_WORD;
      slot_b_background_limits_q <= `ABM_RESET_WORD;
      aux_pin_alternate_select_q <= `ABM_RESET_WORD;
      background_flags_q <= `ABM_RESET_FLAGS;
      reg_rdata_out <= `ABM_RESET_WORD;
      aux_pin_zero_out <= 1'b0;
      aux_pin_one_out <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        offset_q[i] <= `ABM_RESET_WORD;
        count_q[i] <= 5'h00;
      end
    end else begin
      slot_a_background_limits_q <= slot_a_background_limits_d;
      slot_b_background_limits_q <= slot_b_background_limits_d;
      aux_pin_alternate_select_q <= aux_pin_alternate_select_d;
      background_flags_q <= background_flags_d;
      reg_rdata_out <= rdata_d;
      aux_pin_zero_out <= pin0_d;
      aux_pin_one_out <= pin1_d;
      offset_q <= offset_d;
      count_q <= count_d;
    end
  end

  property p_masked_only;
    @(posedge clk_in) disable iff (!rst_n_in)
    sample_valid_in && !subtract && !rd_flags |=>
      count_q[$past(sel_idx)] == $past(sel_cnt);
  endproperty
  a_masked_only: assert property (p_masked_only)
    else $error("Counter moved on an LED pulse.");

  property p_count_up;
    @(posedge clk_in) disable iff (!rst_n_in)
    exceed && !rd_flags && sel_cnt < `ABM_COUNT_L3 |=>
      count_q[$past(sel_idx)] == $past(sel_cnt) + 5'h01;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("Exceedance did not advance the counter.");

  property p_isolated;
    @(posedge clk_in) disable iff (!rst_n_in)
    sample_valid_in && !rd_flags |=>
      count_q[$past(sel_idx) + 3'h1] == $past(count_q[sel_idx + 3'h1]);
  endproperty
  a_isolated: assert property (p_isolated)
    else $error("Another channel's counter changed.");

  property p_flag_sets;
    @(posedge clk_in) disable iff (!rst_n_in)
    exceed && !rd_flags && sel_limit != `ABM_LIMIT_NEVER &&
      sel_cnt + 5'h01 >= sel_need |=> background_flags_q[$past(sel_idx)];
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("Flag missed at the count limit.");

  property p_never_code;
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(background_flags_q[0]) |->
      $past(slot_a_background_limits_q.limit) != `ABM_LIMIT_NEVER;
  endproperty
  a_never_code: assert property (p_never_code)
    else $error("Flag set with limit code zero.");

  property p_read_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
    rd_flags && !sample_valid_in |=>
      background_flags_q == `ABM_RESET_FLAGS &&
      reg_rdata_out[7:0] == $past(background_flags_q);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Flag read did not return and clear.");

  property p_pin_zero;
    @(posedge clk_in) disable iff (!rst_n_in)
    aux_pin_alternate_select_q[4:0] == `ABM_ALT_OR_A |=>
      aux_pin_zero_out == $past(|background_flags_q[3:0]);
  endproperty
  a_pin_zero: assert property (p_pin_zero)
    else $error("First pin wrong for slot A routing.");

  property p_pin_one;
    @(posedge clk_in) disable iff (!rst_n_in)
    aux_pin_alternate_select_q[12:8] == `ABM_ALT_OR_ALL_INT |=>
      aux_pin_one_out == $past((|background_flags_q) | int_in);
  endproperty
  a_pin_one: assert property (p_pin_one)
    else $error("Second pin wrong for flags with interrupt.");

  property p_reset_clear;
    @(posedge clk_in)
    !rst_n_in |=> background_flags_q == `ABM_RESET_FLAGS;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("Flags not cleared by reset.");

endmodule

// File: verif/abm_host.sv
`timescale 1ns/1ns
module abm_host (
  // Clock.
  input wire logic clk_in,
  // Register bus towards the device.
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [15:0] reg_wdata_out,
  input wire logic [15:0] reg_rdata_in
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 16'h0000;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b0;
    // Data lines are scrambled once the strobe is gone.
    reg_wdata_out = ~d;
  endtask

  // The answer is registered, so it is taken one edge after the strobe.
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    reg_rd_out = 1'b0;
    d = reg_rdata_in;
  endtask

  // Polling the flags is how the host learns of excess ambient light.
  task automatic poll(output logic [15:0] d);
    rd(8'h04, d);
  endtask
endmodule

// File: verif/tb_ambient_background_monitor.sv
`timescale 1ns/1ns
`define TB_CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module tb_ambient_background_monitor;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic float_mode_in = 1'b0;
  logic sample_valid_in = 1'b0;
  logic int_in = 1'b0;
  abm_pkg::abm_sample_type sample_in = '0;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic aux0;
  logic aux1;
  logic [15:0] v;
  logic [15:0] raw;
  logic [4:0] codes [4] = '{5'h10, 5'h1a, 5'h1b, 5'h1c};
  int n_errors = 0;
  int cmp_count = 0;
  int thr;
  int off;
  int lim;
  int n;

  initial forever #25 clk_in = ~clk_in;

  abm_monitor #(.ADC_W(14)) u_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .float_mode_in(float_mode_in),
    .sample_valid_in(sample_valid_in), .sample_in(sample_in),
    .int_in(int_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .aux_pin_zero_out(aux0),
    .aux_pin_one_out(aux1));

  abm_host u_host (
    .clk_in(clk_in), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .reg_wdata_out(reg_wdata),
    .reg_rdata_in(reg_rdata));

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic smp(input logic b, input logic [1:0] ch, input logic [1:0] pl,
                     input logic [15:0] r);
    @(posedge clk_in);
    #1;
    sample_valid_in = 1'b1;
    sample_in = '{slot_b: b, channel: ch, pulse: pl, raw: r};
    @(posedge clk_in);
    #1;
    sample_valid_in = 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [15:0] e);
    u_host.rd(a, v);
    `TB_CHK(nm, e, v)
  endtask

  // Pins are registered after the flags, so two edges cover the lag.
  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  function automatic logic exp_pin(logic [4:0] c, logic [7:0] f, logic irq);
    case (c)
      5'h10: return |f[3:0];
      5'h1a: return |f[7:4];
      5'h1b: return |f;
      5'h1c: return |f | irq;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    void'($urandom(32'h32ffaf4e));
    repeat (4) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    rdchk("flags_rst", 8'h04, 16'h0000);
    `TB_CHK("pin0_rst", 1'b0, aux0)
    u_host.wr(8'h0b, 16'hffff);
    rdchk("alt_mask", 8'h0b, 16'h1f1f);
    rdchk("unmapped", 8'h30, 16'h0000);
    $display("test registers done");
    float_mode_in = 1'b1;
    u_host.wr(8'h18, 16'h0005);
    u_host.wr(8'h16, {2'h1, 14'h00a});
    rdchk("limits_a", 8'h16, 16'h400a);
    smp(1'b0, 2'h0, 2'h1, 16'h00ff);
    smp(1'b0, 2'h0, 2'h2, 16'h00ff);
    float_mode_in = 1'b0;
    smp(1'b0, 2'h0, 2'h0, 16'h00ff);
    float_mode_in = 1'b1;
    smp(1'b0, 2'h0, 2'h3, 16'h000f);
    smp(1'b0, 2'h0, 2'h0, 16'h0003);
    rdchk("no_count", 8'h04, 16'h0000);
    smp(1'b0, 2'h0, 2'h3, 16'h0010);
    for (int i = 0; i < 8; i++) begin
      int_in = i[0];
      u_host.wr(8'h0b, {3'h0, codes[i/2], 3'h0, codes[i/2]});
      settle();
      `TB_CHK("pin0", exp_pin(codes[i/2], 8'h01, i[0]), aux0)
      `TB_CHK("pin1", exp_pin(codes[i/2], 8'h01, i[0]), aux1)
    end
    int_in = 1'b0;
    rdchk("flags_a", 8'h04, 16'h0001);
    u_host.poll(v);
    `TB_CHK("flags_clr", 16'h0000, v)
    // With every flag clear only the interrupt can raise a pin.
    int_in = 1'b1;
    u_host.wr(8'h0b, 16'h1c1c);
    settle();
    `TB_CHK("pin0_int", exp_pin(codes[3], 8'h00, 1'b1), aux0)
    `TB_CHK("pin1_int", exp_pin(codes[3], 8'h00, 1'b1), aux1)
    int_in = 1'b0;
    settle();
    `TB_CHK("pin0_noint", exp_pin(codes[3], 8'h00, 1'b0), aux0)
    $display("test slot a done");
    u_host.wr(8'h0b, 16'h1a1a);
    for (int j = 0; j < 4; j++) begin
      lim = (j + 1) % 4;
      n = (lim == 0) ? 20 : (lim == 1) ? 1 : (lim == 2) ? 4 : 16;
      thr = $urandom_range(16, 8000);
      off = $urandom_range(0, 50);
      raw = 16'(thr + off + $urandom_range(1, 200));
      u_host.wr(8'h1c, {2'(lim), 14'(thr)});
      u_host.wr(8'(8'h1e + lim), 16'(off));
      repeat (n - 1) smp(1'b1, 2'(lim), 2'(3 * $urandom_range(0, 1)), raw);
      settle();
      `TB_CHK("pre_limit", 1'b0, aux1)
      smp(1'b1, 2'(lim), 2'h3, raw);
      settle();
      `TB_CHK("at_limit", lim != 0, aux1)
      rdchk("flags_b", 8'h04, (lim == 0) ? 16'h0 : 16'h0010 << lim);
      if (lim == 2) begin
        repeat (3) smp(1'b1, 2'h2, 2'h0, raw);
        rdchk("restart", 8'h04, 16'h0000);
      end
    end
    $display("test limits done");
    test_done();
  end

  initial begin
    #(50 * 20000);
    n_errors++;
    $display("watchdog expired");
    test_done();
  end
endmodule
